// ===== common/lwtf_pkg.sv
// shared constants and carriers for the wakeup timeout flags
package lwtf_pkg;
  localparam int unsigned LWTF_CLK_KHZ = 25000;
  localparam int unsigned LWTF_SHORT_MS = 150;
  localparam int unsigned LWTF_LONG_MS = 1500;
  localparam int unsigned LWTF_SHORT_CYC = LWTF_SHORT_MS * LWTF_CLK_KHZ;
  localparam int unsigned LWTF_LONG_CYC = LWTF_LONG_MS * LWTF_CLK_KHZ;
  localparam int unsigned LWTF_TW = 26;
  localparam int unsigned LWTF_WAKE_ROUND = 3;
  localparam int unsigned LWTF_VW = 5;
  // vector offsets, arbitrary values
  localparam logic [4:0] LWTF_VEC_SINGLE = 5'h06;
  localparam logic [4:0] LWTF_VEC_TRIPLE = 5'h07;
  localparam logic [2:0] LWTF_FLAGS_RST = 3'h0;
  localparam int unsigned LWTF_BIT_TRIPLE = 7;
  localparam int unsigned LWTF_BIT_SINGLE = 6;
  localparam int unsigned LWTF_BIT_RSVD = 5;

  // flag bits 7..5 of the flag register
  typedef struct packed {
    logic triple;
    logic single;
    logic rsvd;
  } lwtf_flags_t;

  typedef struct packed {
    logic rd;
    logic [LWTF_VW-1:0] ofs;
  } lwtf_vec_t;

  typedef enum logic [1:0] {
    LWTF_IDLE = 2'h0,
    LWTF_SHORT = 2'h1,
    LWTF_LONG = 2'h3
  } lwtf_state_t;
endpackage : lwtf_pkg

// ===== hw/lwtf_timer.sv
// down counter that pulses once when a loaded interval runs out
`timescale 1ns/1ps
module lwtf_timer
  import lwtf_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic stop,
  input wire logic [LWTF_TW-1:0] load_val,
  output logic expire_r,
  output logic busy_r
);
  logic [LWTF_TW-1:0] cnt_r;

  always_ff @(posedge clk) begin
    if (sys_rst || stop) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      expire_r <= 1'b0;
    end else if (load) begin
      cnt_r <= load_val;
      busy_r <= 1'b1;
      expire_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 1'b1;
      // pulse lands exactly load_val cycles after the load
      busy_r <= (cnt_r != LWTF_TW'(1));
      expire_r <= (cnt_r == LWTF_TW'(1));
    end else begin
      expire_r <= 1'b0;
    end
  end
endmodule : lwtf_timer

// ===== hw/lwtf_flags.sv
// wakeup timeout flags of the lin controller, bits 7..5
// Operation
// - in lin mode, set single flag when no break follows a sent wakeup
// - wait at least 150 ms after a wakeup before allowing another, unless a break, reset or leaving lin mode ends the round first
// - vector read returning the single flag's offset clears that flag
// - module reset bit, soft reset and system reset clear the flag
// - writing one to bit 7 or bit 6 clears it; zero does nothing
// - bit 5 reads zero, writes ignored
// - in lin mode, set triple flag 1.5 s after three unanswered wakeups
`timescale 1ns/1ps
module lwtf_flags
  import lwtf_pkg::*;
#(
  parameter int unsigned SHORT_CYC = LWTF_SHORT_CYC,
  parameter int unsigned LONG_CYC = LWTF_LONG_CYC
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic lin_mode,
  input wire logic module_reset,
  input wire logic soft_reset_n,
  input wire logic wake_sent,
  input wire logic break_rx,
  input wire logic flag_wr,
  input wire lwtf_flags_t flag_wdata,
  input wire lwtf_vec_t vec,
  output lwtf_flags_t flags_r,
  output logic wake_allowed_r
);
  function automatic logic clr_hit(input logic wr, input logic wbit,
                                   input lwtf_vec_t v,
                                   input logic [LWTF_VW-1:0] ofs);
    clr_hit = (wr && wbit) || (v.rd && v.ofs == ofs);
  endfunction : clr_hit

  lwtf_state_t state_r;
  lwtf_state_t state_nxt;
  logic [1:0] wake_cnt_r;
  logic blk_rst;
  logic abort;
  logic wake_acc;
  logic tmr_load;
  logic [LWTF_TW-1:0] tmr_val;
  logic tmr_exp;
  logic tmr_busy;
  logic set_single;
  logic set_triple;
  logic clr_single;
  logic clr_triple;

  assign blk_rst = module_reset || !soft_reset_n;
  // a break or leaving lin mode ends the wakeup round
  assign abort = blk_rst || break_rx || !lin_mode;
  assign wake_acc = wake_sent && wake_allowed_r && lin_mode &&
                    state_r == LWTF_IDLE && !break_rx && !blk_rst;

  always_comb begin
    state_nxt = state_r;
    tmr_load = 1'b0;
    tmr_val = LWTF_TW'(SHORT_CYC);
    set_single = 1'b0;
    set_triple = 1'b0;
    case (state_r)
      LWTF_IDLE: begin
        if (wake_acc) begin
          state_nxt = LWTF_SHORT;
          tmr_load = 1'b1;
        end
      end
      LWTF_SHORT: begin
        if (tmr_exp) begin
          set_single = 1'b1;
          if (wake_cnt_r == 2'(LWTF_WAKE_ROUND)) begin
            state_nxt = LWTF_LONG;
            tmr_load = 1'b1;
            tmr_val = LWTF_TW'(LONG_CYC);
          end else begin
            state_nxt = LWTF_IDLE;
          end
        end
      end
      LWTF_LONG: begin
        if (tmr_exp) begin
          set_triple = 1'b1;
          state_nxt = LWTF_IDLE;
        end
      end
      default: state_nxt = LWTF_IDLE;
    endcase
    if (abort) begin
      state_nxt = LWTF_IDLE;
      tmr_load = 1'b0;
      set_single = 1'b0;
      set_triple = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= LWTF_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || abort) begin
      wake_cnt_r <= 2'h0;
    end else if (wake_acc) begin
      wake_cnt_r <= wake_cnt_r + 2'h1;
    end else if (set_triple) begin
      wake_cnt_r <= 2'h0;
    end
  end

  // next wakeup only once the timer has gone quiet again
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_allowed_r <= 1'b1;
    end else begin
      wake_allowed_r <= state_nxt == LWTF_IDLE &&
                        !(wake_cnt_r == 2'(LWTF_WAKE_ROUND) &&
                          !abort && !set_triple);
    end
  end

  lwtf_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .stop(abort),
    .load_val(tmr_val),
    .expire_r(tmr_exp),
    .busy_r(tmr_busy)
  );

  assign clr_single = blk_rst ||
    clr_hit(flag_wr, flag_wdata.single, vec, LWTF_VEC_SINGLE);
  assign clr_triple = blk_rst ||
    clr_hit(flag_wr, flag_wdata.triple, vec, LWTF_VEC_TRIPLE);

  // clear is checked first so it wins over a same-cycle set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_r <= LWTF_FLAGS_RST;
    end else begin
      flags_r.rsvd <= 1'b0;
      if (clr_single) begin
        flags_r.single <= 1'b0;
      end else if (set_single) begin
        flags_r.single <= 1'b1;
      end
      if (clr_triple) begin
        flags_r.triple <= 1'b0;
      end else if (set_triple) begin
        flags_r.triple <= 1'b1;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [LWTF_TW-1:0] since_r;
  logic first_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      since_r <= '0;
      first_r <= 1'b1;
    end else if (wake_acc) begin
      since_r <= '0;
      first_r <= 1'b0;
    end else if (since_r != '1) begin
      since_r <= since_r + 1'b1;
    end
  end

  sequence s_short_exp;
    state_r == LWTF_SHORT && tmr_exp && !abort;
  endsequence
  sequence s_long_exp;
    state_r == LWTF_LONG && tmr_exp && !abort;
  endsequence
  sequence s_no_clr_s;
    !clr_single;
  endsequence
  sequence s_round_full;
    s_short_exp ##0 (wake_cnt_r == 2'(LWTF_WAKE_ROUND));
  endsequence

  AST_SINGLE_SET: assert property (s_short_exp ##0 s_no_clr_s |=>
    flags_r.single) else $error("single flag not set on expiry");
  AST_WAKE_GAP: assert property (wake_acc |->
    first_r || since_r >= LWTF_TW'(SHORT_CYC - 1))
    else $error("wakeup accepted too early");
  AST_VEC_CLR: assert property (vec.rd && vec.ofs == LWTF_VEC_SINGLE
    |=> !flags_r.single) else $error("vector read did not clear");
  AST_RST_CLR: assert property (blk_rst |=>
    !flags_r.single && !flags_r.triple) else $error("reset left a flag");
  AST_WR_CLR: assert property (flag_wr && flag_wdata.triple |=>
    !flags_r.triple) else $error("write one did not clear");
  AST_WR_HOLD: assert property (flags_r.single && !clr_single
    |=> flags_r.single) else $error("single flag lost without clear");
  AST_RSVD: assert property (!flags_r.rsvd)
    else $error("reserved bit reads one");
  AST_TRIPLE_SET: assert property (s_long_exp ##0 !clr_triple |=>
    flags_r.triple) else $error("triple flag not set on expiry");
  AST_CLR_WINS: assert property (set_single && clr_single |=>
    !flags_r.single) else $error("set beat clear");
  AST_IDLE_QUIET: assert property (state_r == LWTF_IDLE |->
    !tmr_busy) else $error("timer running while idle");
  AST_LIN_ONLY: assert property (!lin_mode |=>
    state_r == LWTF_IDLE && !tmr_busy)
    else $error("round kept outside lin mode");
  AST_ROUND_LONG: assert property (s_round_full |=>
    state_r == LWTF_LONG) else $error("long wait not started");
  AST_BREAK_END: assert property (break_rx |=>
    state_r == LWTF_IDLE && wake_cnt_r == 2'h0)
    else $error("break did not end the round");
  AST_TRIPLE_HOLD: assert property (flags_r.triple && !clr_triple
    |=> flags_r.triple) else $error("triple flag lost without clear");
endmodule : lwtf_flags

// ===== sim/lwtf_node.sv
// far lin node model that may answer a wakeup with a break field
`timescale 1ns/1ps
module lwtf_node (
  input wire logic clk,
  input wire logic wake_sent,
  input wire logic reply_en,
  input wire logic [7:0] reply_dly,
  output logic break_rx = 1'b0
);
  int cnt = -1;
  // a silent node never answers, so the timeouts can run out
  always_ff @(posedge clk) begin
    break_rx <= 1'b0;
    if (wake_sent && reply_en) begin
      cnt <= reply_dly;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else if (cnt == 0) begin
      break_rx <= 1'b1;
      cnt <= -1;
    end
  end
endmodule : lwtf_node

// ===== sim/testbench.sv
// self-checking bench for the wakeup timeout flags
`timescale 1ns/1ps
module testbench;
  import lwtf_pkg::*;
  localparam int unsigned SC = 20;
  localparam int unsigned LC = 50;
  typedef struct packed {
    logic [1:0] kind;
    logic [2:0] wd;
    logic [4:0] ofs;
    logic exp;
  } lwtf_row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic lin_mode = 1'b1;
  logic module_reset = 1'b0;
  logic soft_reset_n = 1'b1;
  logic wake_sent = 1'b0;
  logic flag_wr = 1'b0;
  logic reply_en = 1'b0;
  logic break_rx;
  logic wake_allowed_r;
  lwtf_flags_t flag_wdata = 3'h0;
  lwtf_flags_t flags_r;
  lwtf_vec_t vec = 6'h00;
  int fail_count = 0;
  int samples_checked = 0;
  // kind: 0 write, 1 vector read, 2 module reset, 3 soft reset
  lwtf_row_t rows [7] = '{'{2'h0, 3'h0, 5'h00, 1'b1},
    '{2'h0, 3'h1, 5'h00, 1'b1}, '{2'h0, 3'h2, 5'h00, 1'b0},
    '{2'h1, 3'h0, LWTF_VEC_TRIPLE, 1'b1}, '{2'h1, 3'h0, LWTF_VEC_SINGLE, 1'b0},
    '{2'h2, 3'h0, 5'h00, 1'b0}, '{2'h3, 3'h0, 5'h00, 1'b0}};
  initial forever #20 clk = ~clk;
  lwtf_flags #(.SHORT_CYC(SC), .LONG_CYC(LC)) i_lwtf_flags (.clk(clk),
    .sys_rst(sys_rst), .lin_mode(lin_mode), .module_reset(module_reset),
    .soft_reset_n(soft_reset_n), .wake_sent(wake_sent), .break_rx(break_rx),
    .flag_wr(flag_wr), .flag_wdata(flag_wdata), .vec(vec),
    .flags_r(flags_r), .wake_allowed_r(wake_allowed_r));
  lwtf_node i_lwtf_node (.clk(clk), .wake_sent(wake_sent),
    .reply_en(reply_en), .reply_dly(8'h0a), .break_rx(break_rx));
  task automatic chk(input string nm, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wake(input logic taken);
    int i;
    #1;
    for (i = 0; i < 200 && wake_allowed_r !== 1'b1; i++) tick(1);
    @(posedge clk);
    wake_sent <= 1'b1;
    @(posedge clk);
    wake_sent <= 1'b0;
    tick(1);
    chk("wake_allowed_r", !taken, wake_allowed_r);
  endtask : wake
  task automatic wait_set(input int idx, input int lim);
    int i;
    for (i = 0; i < lim && flags_r[idx] !== 1'b1; i++) tick(1);
  endtask : wait_set
  task automatic act(input lwtf_row_t r);
    @(posedge clk);
    flag_wr <= (r.kind == 2'h0);
    vec <= {r.kind == 2'h1, r.ofs};
    module_reset <= (r.kind == 2'h2);
    soft_reset_n <= (r.kind != 2'h3);
    flag_wdata <= r.wd;
    @(posedge clk);
    flag_wr <= 1'b0;
    vec <= 6'h00;
    module_reset <= 1'b0;
    soft_reset_n <= 1'b1;
    tick(2);
  endtask : act
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    tick(0);
    chk("flags_r", 1'b1, flags_r === LWTF_FLAGS_RST);
    chk("wake_allowed_r", 1'b1, wake_allowed_r);
    foreach (rows[k]) begin
      wake(1'b1);
      tick(SC - 4);
      chk("wake_allowed_r", 1'b0, wake_allowed_r);
      chk("single", 1'b0, flags_r.single);
      wait_set(1, SC);
      chk("single", 1'b1, flags_r.single);
      act(rows[k]);
      chk("single", rows[k].exp, flags_r.single);
      chk("rsvd", 1'b0, flags_r.rsvd);
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      tick(0);
      chk("single", 1'b0, flags_r.single);
    end
    // answered wakeup must not time out
    @(posedge clk);
    reply_en <= 1'b1;
    wake(1'b1);
    tick(SC + 10);
    chk("single", 1'b0, flags_r.single);
    // outside lin mode the wakeup is not taken
    @(posedge clk);
    reply_en <= 1'b0;
    lin_mode <= 1'b0;
    wake(1'b0);
    tick(SC + 10);
    chk("single", 1'b0, flags_r.single);
    @(posedge clk);
    lin_mode <= 1'b1;
    repeat (3) wake(1'b1);
    wait_set(2, SC + LC + 20);
    chk("triple", 1'b1, flags_r.triple);
    act('{2'h0, 3'h4, 5'h00, 1'b0});
    chk("triple", 1'b0, flags_r.triple);
    // write-one clear lands on the very cycle of the set
    wake(1'b1);
    tick(SC - 2);
    act('{2'h0, 3'h2, 5'h00, 1'b0});
    chk("single", 1'b0, flags_r.single);
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    $display("MISMATCH watchdog expected done seen hang");
    finish_test();
  end
endmodule : testbench
